//--- logic/servo_gain_set_switching.sv
// Purpose: choose first or second gain set for the speed and position loops,
//          and form the filtered torque feedforward term
// Assumes: command inputs are sampled values valid on ctrl_tick_i;
//          torque in 0.1 % rated, speed in rpm, deviation in encoder counts
// Notes:   mode codes 9 and 10 are accepted but hold the first set
// What this block does
// - mode setting 0 to 10 picks switching condition
// - mode 2 follows gain switching digital input
// - mode 3 second set on large torque
// - mode 4 second set on speed change
// - mode 5 second set on high speed
// - return needs below-hysteresis level beyond delay
// - mode 6 second set on position deviation
// - mode 7 second set while position command
// - mode 8 second set until positioning complete
// - second pseudo-derivative coefficient limited to 100 percent
// - torque feedforward is weighted speed command derivative
// - feedforward term passes a settable low-pass
// - threshold and hysteresis scaled, 1000 counts 25 percent
// - delay applies only second-to-first return
`timescale 1ns/1ps
`include "gain_switch_map.svh"
module servo_gain_set_switching
  import gain_switch_pkg::*;
#(
  // cycles per 0.1 ms return delay unit
  parameter int DELAY_UNIT_CYC  = `GSW_DELAY_UNIT_NS / `GSW_CLK_PERIOD_NS,
  // cycles per 0.01 ms filter unit
  parameter int FILTER_UNIT_CYC = `GSW_FILTER_UNIT_NS / `GSW_CLK_PERIOD_NS,
  parameter int CMD_W           = 16,  // torque and speed command width
  parameter int POS_W           = 32   // position deviation width
) (
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    resetn_i,
  // switching settings
  input  wire logic [3:0]              gain_switch_mode_sel_i,
  input  wire logic [15:0]             gain_switch_threshold_i,
  input  wire logic [15:0]             gain_switch_hysteresis_i,
  input  wire logic [13:0]             gain_return_delay_i,
  // gain set settings (0.1 % and 0.1 ms units)
  input  wire logic [9:0]              first_pseudo_deriv_coeff_i,
  input  wire logic [9:0]              second_pseudo_deriv_coeff_i,
  input  wire logic [13:0]             first_speed_integ_tc_i,
  input  wire logic [13:0]             second_speed_integ_tc_i,
  // feedforward settings
  input  wire logic [14:0]             torque_ff_weight_i,
  input  wire logic [12:0]             torque_ff_filter_tc_i,
  // monitored quantities
  input  wire logic                    ctrl_tick_i,
  input  wire logic                    gain_switch_din_i,
  input  wire logic signed [CMD_W-1:0] torque_cmd_i,
  input  wire logic signed [CMD_W-1:0] speed_cmd_i,
  input  wire logic signed [POS_W-1:0] pos_deviation_i,
  input  wire logic                    pos_cmd_active_i,
  input  wire logic                    positioning_done_i,
  // results
  output logic                         gain_sel_second_o,
  output logic [9:0]                   active_pseudo_deriv_coeff_o,
  output logic [13:0]                  active_speed_integ_tc_o,
  output logic signed [31:0]           torque_ff_o
);

  // magnitude of a signed word
  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag32

  // clamp a 0.1 % coefficient to its full scale
  function automatic logic [9:0] clamp_pdff(input logic [9:0] v);
    clamp_pdff = (v > `GSW_PDFF_MAX) ? `GSW_PDFF_MAX : v;
  endfunction : clamp_pdff

  gain_state_e           state;         // current set selection
  gain_state_e           next_state;    // selection after this edge
  logic signed [CMD_W-1:0] speed_prev;  // previous speed command sample
  logic signed [CMD_W:0] speed_delta;   // speed command change per sample
  logic [31:0]           level;         // monitored quantity in counts
  logic [31:0]           hi_level;      // switch-up level
  logic [31:0]           lo_level;      // switch-back level
  logic                  cond_high;     // second set demanded
  logic                  cond_low;      // first set allowed
  logic                  direct_mode;   // mode without delay or hysteresis
  logic                  direct_second; // direct mode wants second set
  logic [31:0]           delay_pre;     // cycle prescaler of delay unit
  logic [13:0]           delay_units;   // delay units elapsed
  logic                  delay_done;    // return delay elapsed
  logic [31:0]           filt_pre;      // cycle prescaler of filter unit
  logic                  filt_tick;     // one pulse per filter unit
  logic signed [31:0]    ff_raw;        // weighted derivative
  logic signed [31:0]    ff_filt;       // smoothed derivative

  // speed command derivative, one difference per control sample
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      speed_prev  <= '0;
      speed_delta <= '0;
    end else if (ctrl_tick_i) begin
      speed_prev  <= speed_cmd_i;
      speed_delta <= {speed_cmd_i[CMD_W-1], speed_cmd_i}
                   - {speed_prev[CMD_W-1], speed_prev};
    end
  end

  // monitored quantity for the selected mode, in threshold counts
  always_comb begin
    unique case (gain_switch_mode_sel_i)
      `GSW_MODE_TORQUE_CMD: begin
        level = 32'(mag32(32'(torque_cmd_i)) * `GSW_TORQUE_SCALE);
      end
      `GSW_MODE_SPEED_CHANGE: begin
        level = 32'(mag32(32'(speed_delta)) * `GSW_SPEED_SCALE);
      end
      `GSW_MODE_SPEED_CMD: begin
        level = 32'(mag32(32'(speed_cmd_i)) * `GSW_SPEED_SCALE);
      end
      `GSW_MODE_POS_DEVIATION: begin
        level = mag32(32'(pos_deviation_i));
      end
      default: begin
        level = '0;  // modes that compare no quantity
      end
    endcase
  end

  // switch-up and switch-back levels; hysteresis floors at zero
  always_comb begin
    hi_level = {16'h0000, gain_switch_threshold_i};
    if (gain_switch_hysteresis_i >= gain_switch_threshold_i) begin
      lo_level = '0;
    end else begin
      lo_level = {16'h0000, gain_switch_threshold_i - gain_switch_hysteresis_i};
    end
  end

  // condition decode per mode
  always_comb begin
    cond_high     = 1'b0;
    cond_low      = 1'b1;
    direct_mode   = 1'b1;
    direct_second = 1'b0;
    unique case (gain_switch_mode_sel_i)
      `GSW_MODE_FIXED_FIRST: begin
        direct_second = 1'b0;
      end
      `GSW_MODE_FIXED_SECOND: begin
        direct_second = 1'b1;
      end
      `GSW_MODE_DIGITAL_IN: begin
        direct_second = gain_switch_din_i;
      end
      `GSW_MODE_TORQUE_CMD,
      `GSW_MODE_SPEED_CHANGE,
      `GSW_MODE_SPEED_CMD,
      `GSW_MODE_POS_DEVIATION: begin
        direct_mode = 1'b0;
        cond_high   = level > hi_level;
        cond_low    = level < lo_level;
      end
      `GSW_MODE_POS_COMMAND: begin
        direct_mode = 1'b0;
        cond_high   = pos_cmd_active_i;
        cond_low    = !pos_cmd_active_i;
      end
      `GSW_MODE_POS_PENDING: begin
        direct_mode = 1'b0;
        cond_high   = !positioning_done_i;
        cond_low    = positioning_done_i;
      end
      default: begin
        direct_second = 1'b0;  // codes 9, 10 and above hold the first set
      end
    endcase
  end

  // delay is over once the full count of units has passed
  assign delay_done = (gain_return_delay_i == '0) || (delay_units >= gain_return_delay_i);

  // selection state machine
  always_comb begin
    next_state = state;
    if (direct_mode) begin
      next_state = direct_second ? ST_SECOND : ST_FIRST;  // no delay in direct modes
    end else begin
      unique case (state)
        ST_FIRST: begin
          if (cond_high) begin
            next_state = ST_SECOND;  // going up is immediate
          end
        end
        ST_SECOND: begin
          if (cond_low && !cond_high) begin
            next_state = (gain_return_delay_i == '0) ? ST_FIRST : ST_RETURN;
          end
        end
        ST_RETURN: begin
          if (!cond_low || cond_high) begin
            next_state = ST_SECOND;  // quantity rose again, restart wait
          end else if (delay_done) begin
            next_state = ST_FIRST;
          end
        end
        default: begin
          next_state = ST_FIRST;  // unused code recovers to a safe set
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_FIRST;
    end else begin
      state <= next_state;
    end
  end

  // return delay counter, runs only while waiting to go back
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      delay_pre   <= '0;
      delay_units <= '0;
    end else if (state != ST_RETURN || next_state != ST_RETURN) begin
      delay_pre   <= '0;
      delay_units <= '0;
    end else if (delay_pre == 32'(DELAY_UNIT_CYC - 1)) begin
      delay_pre <= '0;
      // saturate so a long wait cannot wrap
      if (delay_units != `GSW_DELAY_MAX) begin
        delay_units <= delay_units + 14'h0001;
      end
    end else begin
      delay_pre <= delay_pre + 32'h0000_0001;
    end
  end

  // selection output and the gain set values that go with it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gain_sel_second_o           <= `GSW_RST_STATE_SECOND;
      active_pseudo_deriv_coeff_o <= '0;
      active_speed_integ_tc_o     <= '0;
    end else if (next_state != ST_FIRST) begin
      gain_sel_second_o           <= 1'b1;
      // 100.0 % gives plain PI, 0 leaves integration dominant
      active_pseudo_deriv_coeff_o <= clamp_pdff(second_pseudo_deriv_coeff_i);
      active_speed_integ_tc_o     <= second_speed_integ_tc_i;
    end else begin
      gain_sel_second_o           <= 1'b0;
      active_pseudo_deriv_coeff_o <= clamp_pdff(first_pseudo_deriv_coeff_i);
      active_speed_integ_tc_o     <= first_speed_integ_tc_i;
    end
  end

  // weighted speed command derivative; weight above range is clamped
  always_comb begin
    ff_raw = 32'((32'(speed_delta)
           * $signed({17'h00000, (torque_ff_weight_i > `GSW_FF_WEIGHT_MAX)
                                 ? `GSW_FF_WEIGHT_MAX : torque_ff_weight_i}))
           / `GSW_FF_WEIGHT_DIV);
  end

  // filter time base, one pulse per 0.01 ms
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      filt_pre  <= '0;
      filt_tick <= 1'b0;
    end else if (filt_pre == 32'(FILTER_UNIT_CYC - 1)) begin
      filt_pre  <= '0;
      filt_tick <= 1'b1;
    end else begin
      filt_pre  <= filt_pre + 32'h0000_0001;
      filt_tick <= 1'b0;
    end
  end

  // smoothing of the feedforward term; over-range constants are clamped
  torque_ff_lowpass #(
    .W   (32),
    .TCW (13)
  ) u_ff_lowpass (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .tick_i    (filt_tick),
    .tc_i      ((torque_ff_filter_tc_i > `GSW_FILTER_TC_MAX)
                ? `GSW_FILTER_TC_MAX : torque_ff_filter_tc_i),
    .x_i       (ff_raw),
    .y_o       (ff_filt)
  );

  // feedforward added to the current loop input by the caller
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      torque_ff_o <= '0;
    end else begin
      torque_ff_o <= ff_filt;
    end
  end

endmodule : servo_gain_set_switching

//--- logic/gain_switch_map.svh
// Purpose: constants for the gain set switching block
// Assumes: 50 MHz system clock, one register per setting, plain ports
// Notes:   definitions only
`ifndef GAIN_SWITCH_MAP_SVH
`define GAIN_SWITCH_MAP_SVH

// switching mode codes
`define GSW_MODE_FIXED_FIRST   4'h0
`define GSW_MODE_FIXED_SECOND  4'h1
`define GSW_MODE_DIGITAL_IN    4'h2
`define GSW_MODE_TORQUE_CMD    4'h3
`define GSW_MODE_SPEED_CHANGE  4'h4
`define GSW_MODE_SPEED_CMD     4'h5
`define GSW_MODE_POS_DEVIATION 4'h6
`define GSW_MODE_POS_COMMAND   4'h7
`define GSW_MODE_POS_PENDING   4'h8
`define GSW_MODE_MAX           4'hA

// timing: clock period and setting units
`define GSW_CLK_PERIOD_NS      20
`define GSW_DELAY_UNIT_NS      100000
`define GSW_FILTER_UNIT_NS     10000

// scaling of monitored quantities to threshold counts
`define GSW_TORQUE_SCALE       32'h0000_0004
`define GSW_SPEED_SCALE        32'h0000_0005

// setting limits
`define GSW_LEVEL_MAX          16'h4E20
`define GSW_DELAY_MAX          14'h2710
`define GSW_PDFF_MAX           10'h3E8
`define GSW_FF_WEIGHT_MAX      15'h7530
`define GSW_FILTER_TC_MAX      13'h1900
`define GSW_FF_WEIGHT_DIV      100

// reset values
`define GSW_RST_STATE_SECOND   1'b0

`endif

//--- logic/gain_switch_pkg.sv
// Purpose: shared types of the gain set switching block
// Assumes: constants live in gain_switch_map.svh
// Notes:   types only
package gain_switch_pkg;

  // switching mode selector
  typedef logic [3:0] gain_mode_t;

  // gain set selection state
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,  // first gain set in force
    ST_SECOND = 2'b01,  // second gain set in force
    ST_RETURN = 2'b10   // second set, counting the return delay
  } gain_state_e;

endpackage : gain_switch_pkg

//--- logic/torque_ff_lowpass.sv
// Purpose: first-order low-pass filter for the torque feedforward term
// Assumes: tick_i pulses once per time-constant unit; tc_i in those units
// Notes:   tc_i of zero passes the input straight through
`timescale 1ns/1ps
module torque_ff_lowpass #(
  parameter int W   = 32,  // data width
  parameter int TCW = 13   // time constant width
) (
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  // filter control
  input  wire logic                tick_i,
  input  wire logic [TCW-1:0]      tc_i,
  // data
  input  wire logic signed [W-1:0] x_i,
  output logic signed [W-1:0]      y_o
);

  logic        [TCW:0] den;     // time constant plus one
  logic signed [W:0]   diff;    // distance still to go
  logic signed [W:0]   step;    // move made this tick
  logic signed [W-1:0] next_y;  // filter state after the tick

  // one exponential step per tick: y += (x - y) / (tc + 1)
  always_comb begin
    den    = {1'b0, tc_i} + {{TCW{1'b0}}, 1'b1};
    diff   = {x_i[W-1], x_i} - {y_o[W-1], y_o};
    step   = diff / $signed({1'b0, den});
    next_y = W'({y_o[W-1], y_o} + step);
    // truncation would stall up to tc counts short of the target; jump to it
    if (step == '0 && diff != '0) begin
      next_y = x_i;
    end
  end

  // filter state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      y_o <= '0;
    end else if (tc_i == '0) begin
      y_o <= x_i;  // no smoothing requested
    end else if (tick_i) begin
      y_o <= next_y;
    end
  end

endmodule : torque_ff_lowpass

//--- dv/gain_switch_asserts.sv
// Purpose: concurrent checks on the gain set selection
// Assumes: delay unit shortened in the bench
// Notes:   bound to servo_gain_set_switching
`timescale 1ns/1ps
module gain_switch_asserts #(
  parameter int DELAY_UNIT_CYC = 4  // cycles per return delay unit
) (
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  // settings
  input  wire logic [3:0]         gain_switch_mode_sel_i,
  input  wire logic [15:0]        gain_switch_threshold_i,
  input  wire logic [13:0]        gain_return_delay_i,
  input  wire logic [9:0]         second_pseudo_deriv_coeff_i,
  // monitored quantities
  input  wire logic               gain_switch_din_i,
  input  wire logic signed [15:0] torque_cmd_i,
  input  wire logic signed [15:0] speed_cmd_i,
  input  wire logic signed [31:0] pos_deviation_i,
  input  wire logic               pos_cmd_active_i,
  input  wire logic               positioning_done_i,
  // results
  input  wire logic               gain_sel_second_o,
  input  wire logic [9:0]         active_pseudo_deriv_coeff_o
);
  logic [3:0]         mode;  // short alias of the mode
  logic signed [31:0] thr;   // level in counts
  logic signed [31:0] trq;   // torque scaled to counts
  logic signed [31:0] spd;   // speed scaled to counts
  assign mode = gain_switch_mode_sel_i;
  assign thr  = $signed({16'h0000, gain_switch_threshold_i});
  assign trq  = torque_cmd_i * 4;
  assign spd  = speed_cmd_i * 5;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // a fall with a nonzero delay in torque mode
  sequence s_drop;
    $fell(gain_sel_second_o) && mode == 4'h3 && gain_return_delay_i != 14'h0000;
  endsequence
  // two cycles of an unused mode, so no wait is in flight
  sequence s_unused;
    (mode > 4'h8) [*2];
  endsequence

  property p_fixed_first;  mode == 4'h0 |=> !gain_sel_second_o; endproperty
  property p_fixed_second; mode == 4'h1 |=> gain_sel_second_o; endproperty
  property p_din;  mode == 4'h2 && gain_switch_din_i |=> gain_sel_second_o; endproperty
  property p_torque; mode == 4'h3 && trq > thr |=> gain_sel_second_o; endproperty
  property p_speed;  mode == 4'h5 && spd > thr |=> gain_sel_second_o; endproperty
  property p_pos; mode == 4'h6 && pos_deviation_i > thr |=> gain_sel_second_o; endproperty
  property p_cmd;  mode == 4'h7 && pos_cmd_active_i |=> gain_sel_second_o; endproperty
  property p_pend; mode == 4'h8 && !positioning_done_i |=> gain_sel_second_o; endproperty
  property p_unused; s_unused |=> !gain_sel_second_o; endproperty
  // the wait lasts at least one full delay unit
  property p_delay; s_drop |-> $past(gain_sel_second_o, DELAY_UNIT_CYC); endproperty
  // coefficient follows the second set while it is selected, clamped
  property p_coeff;
    gain_sel_second_o && $stable(second_pseudo_deriv_coeff_i) |-> active_pseudo_deriv_coeff_o ==
      (second_pseudo_deriv_coeff_i > 10'h3E8 ? 10'h3E8 : second_pseudo_deriv_coeff_i);
  endproperty

  a_fixed_first:  assert property (p_fixed_first)  else $error("first set not held");
  a_fixed_second: assert property (p_fixed_second) else $error("second set not held");
  a_din:    assert property (p_din)    else $error("input switch ignored");
  a_torque: assert property (p_torque) else $error("torque switch missed");
  a_speed:  assert property (p_speed)  else $error("speed switch missed");
  a_pos:    assert property (p_pos)    else $error("deviation switch missed");
  a_cmd:    assert property (p_cmd)    else $error("command switch missed");
  a_pend:   assert property (p_pend)   else $error("pending switch missed");
  a_unused: assert property (p_unused) else $error("unused mode chose second");
  a_delay:  assert property (p_delay)  else $error("return came too early");
  a_coeff:  assert property (p_coeff)  else $error("coefficient wrong");
endmodule : gain_switch_asserts

bind servo_gain_set_switching gain_switch_asserts #(.DELAY_UNIT_CYC(DELAY_UNIT_CYC))
  gain_switch_asserts_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .gain_switch_mode_sel_i(gain_switch_mode_sel_i), .gain_return_delay_i(gain_return_delay_i),
  .gain_switch_threshold_i(gain_switch_threshold_i), .gain_switch_din_i(gain_switch_din_i),
  .second_pseudo_deriv_coeff_i(second_pseudo_deriv_coeff_i), .torque_cmd_i(torque_cmd_i),
  .speed_cmd_i(speed_cmd_i), .pos_deviation_i(pos_deviation_i),
  .pos_cmd_active_i(pos_cmd_active_i), .positioning_done_i(positioning_done_i),
  .gain_sel_second_o(gain_sel_second_o),
  .active_pseudo_deriv_coeff_o(active_pseudo_deriv_coeff_o));

//--- dv/tb_top.sv
// Purpose: scenario bench for gain set switching
// Assumes: delay and filter units shortened to 4 cycles
// Notes:   inputs change on falling edges only
`timescale 1ns/1ps
`include "gain_switch_map.svh"
module tb_top;
  localparam int UNIT = 4;  // short unit keeps the run brief
  logic               sys_clk_i = 1'b0;  // 50 MHz clock
  logic               resetn_i  = 1'b0;  // active low reset
  logic [3:0]         mode = 4'h0;       // switching mode
  logic [13:0]        dly  = 14'h0000;   // return delay
  logic [9:0]         c1   = 10'h123;    // first coefficient
  logic [9:0]         c2   = 10'h3FF;    // second, above the clamp
  logic [14:0]        wgt  = 15'h0064;   // feedforward weight
  logic [12:0]        ftc  = 13'h0000;   // filter time constant
  logic               tick = 1'b0;
  logic               din  = 1'b0;
  logic               pcmd = 1'b0;
  logic               done = 1'b1;
  logic signed [15:0] trq  = 16'sh0000;
  logic signed [15:0] spd  = 16'sh0000;
  logic signed [31:0] pdev = 32'sh0000_0000;
  logic               sel;               // second set in force
  logic [9:0]         coeff;
  logic [13:0]        itc;
  logic signed [31:0] ff;
  int                 errors  = 0;
  int                 n_tests = 0;
  int                 cyc     = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  servo_gain_set_switching #(.DELAY_UNIT_CYC(UNIT), .FILTER_UNIT_CYC(UNIT))
    servo_gain_set_switching_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .gain_switch_mode_sel_i(mode), .gain_switch_threshold_i(16'h03E8),
    .gain_switch_hysteresis_i(16'h00C8), .gain_return_delay_i(dly),
    .first_pseudo_deriv_coeff_i(c1), .second_pseudo_deriv_coeff_i(c2),
    .first_speed_integ_tc_i(14'h0011), .second_speed_integ_tc_i(14'h0022),
    .torque_ff_weight_i(wgt), .torque_ff_filter_tc_i(ftc), .ctrl_tick_i(tick),
    .gain_switch_din_i(din), .torque_cmd_i(trq), .speed_cmd_i(spd),
    .pos_deviation_i(pdev), .pos_cmd_active_i(pcmd), .positioning_done_i(done),
    .gain_sel_second_o(sel), .active_pseudo_deriv_coeff_o(coeff),
    .active_speed_integ_tc_o(itc), .torque_ff_o(ff));

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : idle

  task automatic chk_val(input string what, input logic signed [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_val

  // one-cycle sample strobe
  task automatic pulse;
    tick = 1'b1;
    idle(1);
    tick = 1'b0;
  endtask : pulse

  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // hang guard, far above the expected length
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic t_fixed;
    trq = 16'sh012C;  // would trip torque mode
    idle(2);
    chk_val("fixed first", 0, sel);
    chk_val("first coeff", 32'(10'h123), 32'(coeff));
    chk_val("first integ", 32'(14'h0011), 32'(itc));
    mode = `GSW_MODE_FIXED_SECOND;
    idle(2);
    chk_val("fixed second", 1, sel);
    chk_val("clamped coeff", 32'(10'h3E8), 32'(coeff));
    chk_val("second integ", 32'(14'h0022), 32'(itc));
    mode = `GSW_MODE_DIGITAL_IN;
    din = 1'b1;
    idle(2);
    chk_val("input high", 1, sel);
    din = 1'b0;
    idle(2);
    chk_val("input low", 0, sel);
    trq = 16'sh0000;
  endtask : t_fixed

  // drive the monitored quantity of a mode above or below the level
  task automatic set_level(input logic [3:0] m, input logic hi);
    case (m)
      4'h3: trq = hi ? 16'sh012C : 16'sh0064;
      4'h4: begin
        if (hi) begin
          spd = 16'sh0000;
          pulse();
          idle(1);  // let the strobe fall before the next sample
          spd = 16'sh0190;
        end
        pulse();  // second sample: 0 to 400 when high, same speed again (zero change) when low
      end
      4'h5: spd = hi ? 16'sh012C : 16'sh0064;
      4'h6: pdev = hi ? 32'sh0000_05DC : 32'sh0000_01F4;
      4'h7: pcmd = hi;
      default: done = !hi;
    endcase
  endtask : set_level

  task automatic t_modes;
    for (int m = 3; m <= 8; m++) begin
      mode = 4'(m);
      set_level(4'(m), 1'b1);
      idle(3);
      chk_val("cause present", 1, sel);
      set_level(4'(m), 1'b0);
      idle(3);
      chk_val("cause gone", 0, sel);
    end
  endtask : t_modes

  task automatic t_return;
    int n;
    mode = `GSW_MODE_TORQUE_CMD;
    dly = 14'h0001;
    trq = 16'sh00FA;  // exactly on the level, not above
    idle(3);
    chk_val("on level", 0, sel);
    trq = 16'sh012C;
    idle(2);
    chk_val("above level", 1, sel);
    trq = 16'sh00DC;  // inside the hysteresis band
    idle(12);
    chk_val("in band", 1, sel);
    trq = 16'sh0064;
    n = 0;
    while (sel === 1'b1 && n < 20) begin
      idle(1);
      n++;
    end
    chk_val("delay span", 1, 32'(n >= UNIT && n <= UNIT + 4));
    dly = 14'h0000;
    trq = 16'sh012C;
    idle(2);
    for (int m = 9; m <= 10; m++) begin
      mode = 4'(m);
      idle(3);
      chk_val("unused mode", 0, sel);
    end
    mode = `GSW_MODE_FIXED_FIRST;
  endtask : t_return

  task automatic t_ff;
    spd = 16'sh000A;
    pulse();
    idle(3);
    // previous sample is still 400 from the speed change scenario
    chk_val("ff unit weight", -32'sh0000_0186, ff);
    wgt = 15'h00FA;
    spd = 16'sh0004;
    pulse();
    idle(3);
    chk_val("ff negative", -32'sh0000_000F, ff);
    wgt = 15'h7FFF;  // above the clamp
    spd = 16'sh0005;
    pulse();
    idle(3);
    chk_val("ff clamp", 32'sh0000_012C, ff);
    ftc = 13'h0064;
    spd = 16'sh0069;
    pulse();
    idle(20);
    // must have left the old value yet not reached the new one
    chk_val("ff lags", 1, 32'(ff > 32'sh0000_012C && ff < 32'sh0000_7530));
    ftc = 13'h0001;
    idle(400);
    chk_val("ff settles", 32'sh0000_7530, ff);
  endtask : t_ff

  initial begin
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    chk_val("after reset", 0, sel);
    t_fixed();
    t_modes();
    t_return();
    t_ff();
    summarize();
  end
endmodule : tb_top
